// *** verification/rdsw_host.sv ***
// Host side model: keeps the last descriptor word written back and counts the writes
`default_nettype none
module rdsw_host
	import rdsw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic wbValid,
	input wire logic [STAT_W-1:0] wbWord,
	output logic [STAT_W-1:0] seenWord,
	output int seenCnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// Software only sees a word once it is written
	initial begin
		seenWord = '0;
		seenCnt = 0;
	end
	always @(posedge clk_sys) begin
		if (wbValid) begin
			seenWord <= wbWord;
			seenCnt <= seenCnt + 1;
		end
	end
endmodule : rdsw_host
`default_nettype wire

// *** verification/rdsw_sva.sv ***
// Port assertions for the descriptor status word builder
`default_nettype none
module rdsw_sva
	import rdsw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic bufValid,
	input wire logic bufSof,
	input wire logic bufEof,
	input wire logic bufHdr,
	input wire logic wbValid,
	input wire logic [STAT_W-1:0] wbWord,
	input wire logic txStartPulse,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_rvalid,
	input wire logic s_rready
);
	// One clock domain, so one default for all checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// Frame markers follow the event one cycle later
	eof_bit_a: assert property (bufValid |=> wbWord[DW_EOF] == $past(bufEof))
		else $error("end of frame bit wrong");
	sof_bit_a: assert property (bufValid |=> wbWord[DW_SOF] == $past(bufSof))
		else $error("start of frame bit wrong");
	wb_pulse_a: assert property (bufValid |=> wbValid)
		else $error("status word not written");
	// Word holds between events, no stray write
	no_event_a: assert property (!bufValid |=> !wbValid && $stable(wbWord))
		else $error("word changed without event");
	mid_len_a: assert property (bufValid && !bufEof |=> !wbWord[DW_B13])
		else $error("bit 13 set before end of frame");
	eof_hdr_a: assert property (bufValid && bufEof |=> !wbWord[DW_HDR_LAST])
		else $error("header end set on last buffer");
	hdr_mark_a: assert property (bufValid && !bufEof && !bufHdr |=> !wbWord[DW_B16])
		else $error("header mark without header");
	// Bus answers stand until taken
	bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
		else $error("write answer dropped");
	rresp_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid)
		else $error("read answer dropped");
	tx_pulse_a: assert property (txStartPulse |=> !txStartPulse)
		else $error("transmit start too long");
endmodule : rdsw_sva
bind rdsw_writeback rdsw_sva rdsw_sva_i (.clk_sys(clk_sys), .arst_n(arst_n),
	.bufValid(bufValid), .bufSof(bufSof), .bufEof(bufEof), .bufHdr(bufHdr),
	.wbValid(wbValid), .wbWord(wbWord), .txStartPulse(txStartPulse),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_rvalid(s_rvalid),
	.s_rready(s_rready));
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the descriptor status word builder
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb;
	import rdsw_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [31:0] nc;
		logic [31:0] dc;
		logic [5:0] ev;
		logic [17:0] ex;
	} rdsw_row_t;
	logic clk_sys, arst_n, bufValid, bufSof, bufEof, bufHdr, bufHdrLast;
	logic fcsBad, vlanTagged, cfiBit, txDone, wbValid, irq, txStartPulse;
	logic [12:0] hdrLen;
	logic [13:0] frameLen;
	logic [17:0] wbWord, seenWord;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, d;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, r;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	int seenCnt, n0, n_mismatch, check_count, txSeen;
	logic mgmtEnable, fullDuplex;
	logic [1:0] speedSel;
	// Event bits {sof, eof, hdr, hdrLast, fcsBad, cfi}; length 0x2105
	localparam rdsw_row_t ROWS[8] = '{
		'{32'h0, 32'h0, 6'h31, 18'h1c105},
		'{32'h8, 32'h2000, 6'h12, 18'h1a105},
		'{32'h4000000, 32'h0, 6'h12, 18'h0a105},
		'{32'h20008, 32'h0, 6'h10, 18'h0a101},
		'{32'h20000, 32'h0, 6'h10, 18'h08101},
		'{32'h0, 32'h20, 6'h28, 18'h14000},
		'{32'h0, 32'h20, 6'h0c, 18'h30033},
		'{32'h0, 32'h0, 6'h2e, 18'h04000}};
	rdsw_writeback rdsw_writeback_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.bufValid(bufValid), .bufSof(bufSof), .bufEof(bufEof), .bufHdr(bufHdr),
		.bufHdrLast(bufHdrLast), .hdrLen(hdrLen), .frameLen(frameLen),
		.fcsBad(fcsBad), .vlanTagged(vlanTagged), .cfiBit(cfiBit),
		.txDone(txDone), .wbValid(wbValid), .wbWord(wbWord),
		.mgmtEnable(mgmtEnable), .txStartPulse(txStartPulse),
		.fullDuplex(fullDuplex), .speedSel(speedSel), .irq(irq),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready));
	rdsw_host rdsw_host_i (.clk_sys(clk_sys), .wbValid(wbValid),
		.wbWord(wbWord), .seenWord(seenWord), .seenCnt(seenCnt));
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Counts transmit start pulses seen on the pin
	always @(posedge clk_sys) begin
		if (txStartPulse) txSeen <= txSeen + 1;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ga, gw, gb;
		gb = 1'h0;
		@(posedge clk_sys);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		for (int n = 0; n < 40 && !gb; n++) begin
			@(negedge clk_sys);
			ga = s_awvalid & s_awready;
			gw = s_wvalid & s_wready;
			gb = s_bvalid & s_bready;
			r = s_bresp;
			@(posedge clk_sys);
			if (ga) s_awvalid <= 1'h0;
			if (gw) s_wvalid <= 1'h0;
			if (gb) s_bready <= 1'h0;
		end
		if (!gb) begin
			n_mismatch++;
			test_done();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ga, gr;
		gr = 1'h0;
		@(posedge clk_sys);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		for (int n = 0; n < 40 && !gr; n++) begin
			@(negedge clk_sys);
			ga = s_arvalid & s_arready;
			gr = s_rvalid & s_rready;
			d = s_rdata;
			r = s_rresp;
			@(posedge clk_sys);
			if (ga) s_arvalid <= 1'h0;
			if (gr) s_rready <= 1'h0;
		end
		if (!gr) begin
			n_mismatch++;
			test_done();
		end
	endtask : rd
	// One buffer event, then wait until the host holds its word
	task automatic ev(input logic [5:0] e);
		@(posedge clk_sys);
		{bufSof, bufEof, bufHdr, bufHdrLast, fcsBad, cfiBit} <= e;
		bufValid <= 1'h1;
		@(posedge clk_sys);
		bufValid <= 1'h0;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask : ev
	initial begin
		{arst_n, bufValid, bufSof, bufEof, bufHdr, bufHdrLast} = '0;
		{fcsBad, cfiBit, txDone, s_awvalid, s_wvalid, s_bready} = '0;
		{s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
		{n_mismatch, check_count, txSeen} = '0;
		s_wstrb = 4'hf;
		vlanTagged = 1'h1;
		frameLen = 14'h2105;
		hdrLen = 13'h0033;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rd(OFS_NET_CFG);
		`CHK("config after reset", 32'h0, d)
		rd(8'hfc);
		`CHK("unmapped answer", RESP_SLVERR, r)
		foreach (ROWS[i]) begin
			wr(OFS_NET_CFG, ROWS[i].nc);
			wr(OFS_DMA_CFG, ROWS[i].dc);
			ev(ROWS[i].ev);
			`CHK("status word", ROWS[i].ex, seenWord)
		end
		// Back to back: split on, start only, then end of frame
		wr(OFS_DMA_CFG, 32'h20);
		wr(OFS_NET_CFG, 32'h0);
		n0 = seenCnt;
		{bufSof, bufEof, bufHdr, bufHdrLast, fcsBad, cfiBit} <= 6'h20;
		bufValid <= 1'h1;
		@(posedge clk_sys);
		{bufSof, bufEof} <= 2'h1;
		@(negedge clk_sys);
		`CHK("first word", 18'h04000, wbWord)
		@(posedge clk_sys);
		bufValid <= 1'h0;
		@(negedge clk_sys);
		`CHK("second word", 18'h08105, wbWord)
		@(negedge clk_sys);
		`CHK("word count", n0 + 2, seenCnt)
		// Interrupt: old bits cleared first so the raise is real
		wr(OFS_INT_STAT, 32'h7);
		wr(OFS_INT_MASK, 32'h1);
		@(negedge clk_sys);
		`CHK("irq idle", 1'h0, irq)
		ev(6'h10);
		`CHK("irq raised", 1'h1, irq)
		rd(OFS_INT_STAT);
		`CHK("done status", 1'h1, d[IRQ_DONE])
		wr(OFS_INT_STAT, 32'h1);
		@(negedge clk_sys);
		`CHK("irq cleared", 1'h0, irq)
		wr(OFS_INT_MASK, 32'h0);
		ev(6'h10);
		`CHK("irq masked", 1'h0, irq)
		// Control: start, management enable and counter clear at once
		wr(OFS_NET_CTRL, 32'h230);
		`CHK("start answer", RESP_OKAY, r)
		@(negedge clk_sys);
		`CHK("start pulse", 1, txSeen)
		`CHK("management on", 1'h1, mgmtEnable)
		wr(OFS_NET_CFG, 32'h403);
		@(negedge clk_sys);
		`CHK("duplex", 1'h1, fullDuplex)
		`CHK("speed", 2'h3, speedSel)
		rd(OFS_RX_CNT);
		`CHK("count cleared", 32'h0, d)
		ev(6'h10);
		rd(OFS_RX_CNT);
		`CHK("count one", 32'h1, d)
		test_done();
	end
endmodule : tb
`default_nettype wire

// *** verilog/rdsw_pkg.sv ***
// Package for the receive descriptor status word builder
`default_nettype none
package rdsw_pkg;
	// Register byte offsets on the register bus
	localparam logic [7:0] OFS_NET_CTRL = 8'h00;
	localparam logic [7:0] OFS_NET_CFG = 8'h04;
	localparam logic [7:0] OFS_NET_STAT = 8'h08;
	localparam logic [7:0] OFS_DMA_CFG = 8'h10;
	localparam logic [7:0] OFS_INT_STAT = 8'h24;
	localparam logic [7:0] OFS_INT_MASK = 8'h28;
	localparam logic [7:0] OFS_RX_CNT = 8'h2c;
	localparam logic [7:0] OFS_ERR_CNT = 8'h30;
	localparam logic [7:0] OFS_TX_CNT = 8'h34;
	localparam logic [7:0] OFS_LAST_WORD = 8'h38;
	// Network configuration fields
	localparam int NCFG_JUMBO = 3;
	localparam int NCFG_FCS_DISCARD = 17;
	localparam int NCFG_IGN_FCS = 26;
	localparam int NCFG_FULL_DUPLEX = 1;
	localparam int NCFG_SPEED_LO = 0;
	localparam int NCFG_GIGA = 10;
	// DMA configuration fields
	localparam int DCFG_HDR_SPLIT = 5;
	localparam int DCFG_BAD_FCS_REP = 13;
	// Network control fields
	localparam int NCTL_MGMT_EN = 4;
	localparam int NCTL_TX_START = 9;
	localparam int NCTL_CLR_STATS = 5;
	// Descriptor word fields
	localparam int DW_HDR_LAST = 17;
	localparam int DW_B16 = 16;
	localparam int DW_EOF = 15;
	localparam int DW_SOF = 14;
	localparam int DW_B13 = 13;
	localparam int LEN_W = 13;
	localparam int STAT_W = 18;
	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FCS_ERR = 1;
	localparam int IRQ_TX_START = 2;
	localparam int IRQ_W = 3;
	// Value after reset and FCS length in bytes
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [13:0] FCS_BYTES = 14'h0004;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rdsw_pkg
`default_nettype wire

// *** verilog/rdsw_writeback.sv ***
// Receive descriptor status word builder with register slave
//
// Summary of operation
// - Split on, not last: bit 16 marks header
// - Last, bad-FCS report set: bit 16 is FCS error
// - Last, report clear, VLAN: bit 16 is CFI
// - Bit 15 set on end of frame
// - Bit 14 set on start of frame
// - Not last, no split: only bit 14 valid
// - Not last, split on: bits 16, 17 valid
// - Jumbo mode: bit 13 is length MSB
// - Ignore-FCS without jumbo: bit 13 is FCS status
// - Neither mode: bit 13 is zero
// - Split and last header: bits 12:0 header length
// - Discard off: length includes FCS
// - Discard on: length excludes FCS
// - Registers reached over the bus slave
// - Control registers: management, DMA, transmit, speed
// - Statistics counters for receive and transmit events
// - Split on: bit 17 on last header buffer
//
// Operation notes
// One buffer event in, one status word out
// Event taken on the edge where bufValid is high
// Word and its valid strobe follow one clock later
// wbValid stands for one cycle per event
// wbWord holds until the next buffer event
// Back-to-back events are taken without gaps
// No buffering: a host too slow loses words
//
// Word layout, bits 17 down to 0
// Bit 17: last header buffer, split mode only
// Bit 16: header mark, FCS error or CFI
// Bit 15: end of frame
// Bit 14: start of frame
// Bit 13: jumbo length MSB or FCS status
// Bits 12:0: header or frame length
//
// Bit 16 on the last buffer
// Report mode set: carries the FCS error
// Report mode clear: CFI of a tagged frame
// Untagged frame with report clear reads zero
// Bit 16 on other buffers
// Split on: buffer holds header bytes
// Split off: always zero, not valid status
//
// Bit 13 priority
// Jumbo mode wins over ignore-FCS mode
// Both off: bit 13 forced to zero
// Never set on a buffer that is not last
//
// Length field
// Last buffer: frame length, FCS kept or trimmed
// Trimmed length floors at zero on runt input
// Last header buffer: header length in bytes
// Any other buffer: field reads zero
// Jumbo length above 14 bits is not reported
//
// Register map, byte offsets on the bus
// 0x00 network control, bit 5 clears counters
// 0x04 network configuration
// 0x08 network status, read only
// 0x10 DMA configuration
// 0x24 interrupt status, write one to clear
// 0x28 interrupt mask, one enables
// 0x2c received end-of-frame words
// 0x30 received frames with bad FCS
// 0x34 transmit events
// 0x38 last status word written
// Other offsets answer with a slave error
//
// Bus behaviour
// Address and data accepted in either order
// Each ready drops while its item is held
// Response one cycle after both are held
// Only one write and one read in flight
// Read data registered with its valid
// Byte strobes merge into the control and configuration registers; the interrupt mask takes only the strobed bits
//
// Interrupts
// Bit 0: end-of-frame word written
// Bit 1: end of frame with bad FCS
// Bit 2: transmit start requested
// A new event wins over a same-cycle clear
// irq is a level, high while any enabled bit set
//
// Counters
// Wrap silently at full scale
// A clear still keeps an event of that cycle
// Width set by a parameter, read as one word
//
// Reset
// Pin reset asynchronous, release synchronised
// Whole block leaves reset on one clock edge
// Configuration defaults to all modes off
//
// Limitations
// Mode bits are sampled live, not per frame
// Changing a mode mid-frame mixes meanings
// Software should set modes while receive idles
// Frame length is trusted as given
// No check that end of frame had a start
// Header length is passed through unchanged
//
// Trade-offs
// Decode is plain logic for short timing paths
// Read mux follows the address combinationally
// Read is one cycle, no wait states inserted
`default_nettype none
module rdsw_writeback
	import rdsw_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	// Buffer event from the receive path
	input wire logic bufValid,
	input wire logic bufSof,
	input wire logic bufEof,
	input wire logic bufHdr,
	input wire logic bufHdrLast,
	input wire logic [LEN_W-1:0] hdrLen,
	input wire logic [13:0] frameLen,
	input wire logic fcsBad,
	input wire logic vlanTagged,
	input wire logic cfiBit,
	input wire logic txDone,
	// Descriptor status word out
	output logic wbValid,
	output logic [STAT_W-1:0] wbWord,
	// Control outputs
	output logic mgmtEnable,
	output logic txStartPulse,
	output logic fullDuplex,
	output logic [1:0] speedSel,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	import rdsw_pkg::*;

	logic rstMeta, rstSync;
	logic [31:0] netCtrl_reg, netCfg_reg, dmaCfg_reg;
	logic [IRQ_W-1:0] intStat_reg, intMask_reg, intEvt;
	logic [CNT_W-1:0] rxCnt_reg, errCnt_reg, txCnt_reg;
	logic [STAT_W-1:0] wbWord_next;
	logic awHeld_reg, wHeld_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic txStart_reg;

	// Reset released through two flops so all logic leaves reset together
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// Mode selects from configuration registers
	wire splitEn = dmaCfg_reg[DCFG_HDR_SPLIT];
	wire badFcsRep = dmaCfg_reg[DCFG_BAD_FCS_REP];
	wire jumboEn = netCfg_reg[NCFG_JUMBO];
	wire ignFcsEn = netCfg_reg[NCFG_IGN_FCS];
	wire fcsDiscard = netCfg_reg[NCFG_FCS_DISCARD];

	// Frame length: FCS trimmed in discard mode
	wire [13:0] lenNoFcs = (frameLen > FCS_BYTES) ?
		14'(frameLen - FCS_BYTES) : 14'h0000;
	wire [13:0] lenOut = fcsDiscard ? lenNoFcs : frameLen;

	// Bit 16 meaning depends on last-buffer and report mode
	wire bit16Last = badFcsRep ? fcsBad
		: (vlanTagged & cfiBit);
	wire bit16 = bufEof ? bit16Last
		: (splitEn & bufHdr);
	// Bit 17 only valid with splitting on a non-last buffer
	wire bit17 = splitEn & bufHdrLast & ~bufEof;

	// Bit 13: jumbo length MSB beats ignore-FCS status
	wire bit13 = !bufEof ? 1'b0
		: jumboEn ? lenOut[13]
		: ignFcsEn ? fcsBad
		: 1'b0;

	// Low length field: header length or frame length
	wire [LEN_W-1:0] lenField = bufEof ? lenOut[LEN_W-1:0]
		: bit17 ? hdrLen
		: {LEN_W{1'b0}};

	// Non-last buffer without split reports only start of frame
	always_comb begin
		wbWord_next = '0;
		wbWord_next[DW_SOF] = bufSof;
		wbWord_next[DW_EOF] = bufEof;
		if (bufEof || splitEn) begin
			wbWord_next[DW_B16] = bit16;
			wbWord_next[DW_HDR_LAST] = bit17;
		end
		if (bufEof || bit17) begin
			wbWord_next[LEN_W-1:0] = lenField;
		end
		wbWord_next[DW_B13] = bit13;
	end

	// Status word registered once per buffer event
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			wbValid <= 1'b0;
			wbWord <= '0;
		end else begin
			wbValid <= bufValid;
			if (bufValid) begin
				wbWord <= wbWord_next;
			end
		end
	end

	// Bus write decode: address and data may arrive in either order
	wire wrFire = awHeld_reg & wHeld_reg & ~s_bvalid;
	wire wrCtrl = wrFire && awAddr_reg == OFS_NET_CTRL;
	wire wrCfg = wrFire && awAddr_reg == OFS_NET_CFG;
	wire wrDma = wrFire && awAddr_reg == OFS_DMA_CFG;
	wire wrIstat = wrFire && awAddr_reg == OFS_INT_STAT;
	wire wrImask = wrFire && awAddr_reg == OFS_INT_MASK;
	wire wrHit = wrCtrl | wrCfg | wrDma | wrIstat | wrImask;
	wire [31:0] bMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
		{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
	wire [31:0] wMerged = wData_reg & bMask;
	wire clrStats = wrCtrl & wMerged[NCTL_CLR_STATS];

	assign s_awready = ~awHeld_reg;
	assign s_wready = ~wHeld_reg;

	// Write channel capture and response
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= RST_ZERO;
			wStrb_reg <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_wdata;
				wStrb_reg <= s_wstrb;
			end
			if (wrFire) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Control and configuration registers, byte-lane merged; interrupt mask takes the strobed bits unmerged
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			netCtrl_reg <= RST_ZERO;
			netCfg_reg <= RST_ZERO;
			dmaCfg_reg <= RST_ZERO;
			intMask_reg <= '0;
			txStart_reg <= 1'b0;
		end else begin
			txStart_reg <= wrCtrl & wMerged[NCTL_TX_START];
			if (wrCtrl) begin
				netCtrl_reg <= (netCtrl_reg & ~bMask) | wMerged;
			end
			if (wrCfg) begin
				netCfg_reg <= (netCfg_reg & ~bMask) | wMerged;
			end
			if (wrDma) begin
				dmaCfg_reg <= (dmaCfg_reg & ~bMask) | wMerged;
			end
			if (wrImask) begin
				intMask_reg <= wMerged[IRQ_W-1:0];
			end
		end
	end

	// Sticky interrupt bits; a new event wins over a clear
	assign intEvt[IRQ_DONE] = wbValid & wbWord[DW_EOF];
	assign intEvt[IRQ_FCS_ERR] = bufValid & bufEof & fcsBad;
	assign intEvt[IRQ_TX_START] = txStart_reg;
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			intStat_reg <= '0;
		end else begin
			intStat_reg <= (intStat_reg &
				~(wrIstat ? wMerged[IRQ_W-1:0] : '0)) | intEvt;
		end
	end
	assign irq = |(intStat_reg & intMask_reg);

	// Statistics counters; counting is kept over a same-cycle clear
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			rxCnt_reg <= '0;
			errCnt_reg <= '0;
			txCnt_reg <= '0;
		end else if (clrStats) begin
			rxCnt_reg <= CNT_W'(intEvt[IRQ_DONE]);
			errCnt_reg <= CNT_W'(intEvt[IRQ_FCS_ERR]);
			txCnt_reg <= CNT_W'(txDone);
		end else begin
			rxCnt_reg <= rxCnt_reg + CNT_W'(intEvt[IRQ_DONE]);
			errCnt_reg <= errCnt_reg + CNT_W'(intEvt[IRQ_FCS_ERR]);
			txCnt_reg <= txCnt_reg + CNT_W'(txDone);
		end
	end

	// Read decode from the live address, registered on the edge the address is taken
	wire [31:0] netStat = {29'h0, intStat_reg != '0, wbValid, irq};
	wire rdHit = s_araddr == OFS_NET_CTRL || s_araddr == OFS_NET_CFG ||
		s_araddr == OFS_NET_STAT || s_araddr == OFS_DMA_CFG ||
		s_araddr == OFS_INT_STAT || s_araddr == OFS_INT_MASK ||
		s_araddr == OFS_RX_CNT || s_araddr == OFS_ERR_CNT ||
		s_araddr == OFS_TX_CNT || s_araddr == OFS_LAST_WORD;
	wire [31:0] rdMux =
		(s_araddr == OFS_NET_CTRL) ? netCtrl_reg :
		(s_araddr == OFS_NET_CFG) ? netCfg_reg :
		(s_araddr == OFS_NET_STAT) ? netStat :
		(s_araddr == OFS_DMA_CFG) ? dmaCfg_reg :
		(s_araddr == OFS_INT_STAT) ? 32'(intStat_reg) :
		(s_araddr == OFS_INT_MASK) ? 32'(intMask_reg) :
		(s_araddr == OFS_RX_CNT) ? 32'(rxCnt_reg) :
		(s_araddr == OFS_ERR_CNT) ? 32'(errCnt_reg) :
		(s_araddr == OFS_TX_CNT) ? 32'(txCnt_reg) :
		(s_araddr == OFS_LAST_WORD) ? 32'(wbWord) : RST_ZERO;
	assign s_arready = ~s_rvalid;

	// Read response held until the master takes it
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			s_rvalid <= 1'b0;
			s_rdata <= RST_ZERO;
			s_rresp <= RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata <= rdMux;
			s_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// Control pins follow the control and configuration registers
	assign mgmtEnable = netCtrl_reg[NCTL_MGMT_EN];
	assign txStartPulse = txStart_reg;
	assign fullDuplex = netCfg_reg[NCFG_FULL_DUPLEX];
	assign speedSel = {netCfg_reg[NCFG_GIGA], netCfg_reg[NCFG_SPEED_LO]};
endmodule : rdsw_writeback
`default_nettype wire
